// ===== hdl/wide_load_instr_exec.sv
// fetch, decode and execution of the refresh load and sixteen-bit loads
`timescale 1ns/1ps
// Behaviour
// - The prefixed refresh load copies the accumulator into refresh in 4+5 states, flags kept.
// - Pair field 00/01/10/11 picks first, second, third pair or stack pointer; immediate load takes 10 states.
// - Of any 16-bit operand the first byte fetched is the low half, the next the high half.
// - Prefix DD with opcode 21 loads index_x with the following word in 4 cycles, 14 states.
// - Prefix FD with opcode 21 loads index_y with the following word in 4 cycles, 14 states.
// - Opcode 2A loads third_pair low from the address and high from address+1 in 16 states.
// - The prefixed direct load of a selected pair reads low then high byte in 20 states.
// - Prefix DD with opcode 2A loads index_x from address and address+1 in 20 states.
// - Prefix FD with opcode 2A loads index_y from address and address+1 in 6 cycles.
// - Opcode 22 stores third_pair low to the address and high to address+1 in 16 states.
// - The prefixed direct store writes the selected pair low then high, same pair coding.
// - The prefixed direct store takes 6 cycles of 20 states and keeps the flags.
module wide_load_instr_exec (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  // memory cycles
  output logic      [15:0] mem_addr_out,
  output logic             mem_rd_out,
  output logic             mem_wr_out,
  output logic      [7:0]  mem_wdata_out,
  input  wire logic [7:0]  mem_rdata_in,
  // core side
  input  wire logic [7:0]  acc_in,
  input  wire logic        flags_wr_in,
  input  wire logic [7:0]  flags_in,
  // register state
  output logic      [15:0] first_pair_out,
  output logic      [15:0] second_pair_out,
  output logic      [15:0] third_pair_out,
  output logic      [15:0] stack_pointer_out,
  output logic      [15:0] index_x_out,
  output logic      [15:0] index_y_out,
  output logic      [7:0]  refresh_out,
  output logic      [7:0]  flags_out,
  output logic             instr_done_out
);
  wide_load_pkg::state_t st_r, st_nxt;
  wide_load_pkg::pfx_t   pfx_r, pfx_nxt, dec_pfx;
  logic [7:0]  op_r, lo_r, refresh_r, flags_r, wdata_r, wd_nxt;
  logic [15:0] pc_r, ea_r, ea_nxt, addr_r, rp_r [0:5];
  logic        rd_r, wr_r, done_r, reg_we, tick;
  logic [2:0]  len_nxt, sel;

  tstate_timer u_timer (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .len_in   (len_nxt),
    .last_out (tick)
  );

  // decode
  wire        in_fetch  = (st_r == wide_load_pkg::ST_FETCH);
  wire        code_rd   = in_fetch || st_r == wide_load_pkg::ST_FETCH2 ||
                          st_r == wide_load_pkg::ST_OPLO || st_r == wide_load_pkg::ST_OPHI;
  wire [7:0]  dec_op    = (in_fetch || st_r == wide_load_pkg::ST_FETCH2) ? mem_rdata_in : op_r;
  assign dec_pfx = in_fetch ? wide_load_pkg::PFX_NONE : pfx_r;
  wire        is_prefix = in_fetch && (mem_rdata_in == wide_load_pkg::PFX_X ||
                          mem_rdata_in == wide_load_pkg::PFX_Y || mem_rdata_in == wide_load_pkg::PFX_E);
  wire        no_pfx    = (dec_pfx == wide_load_pkg::PFX_NONE);
  wire        is_ed     = (dec_pfx == wide_load_pkg::PFX_EXT);
  wire        is_idx    = (dec_pfx == wide_load_pkg::PFX_IDX_X) || (dec_pfx == wide_load_pkg::PFX_IDX_Y);
  wire        imm_pair  = no_pfx && dec_op[7:6] == wide_load_pkg::GRP_IMM &&
                          dec_op[3:0] == wide_load_pkg::LOW_IMM;
  wire        imm_idx   = is_idx && dec_op == wide_load_pkg::OP_IDX_IMM;
  wire        ld_hl     = no_pfx && dec_op == wide_load_pkg::OP_LD_DIR;
  wire        st_hl     = no_pfx && dec_op == wide_load_pkg::OP_ST_DIR;
  wire        ld_ed     = is_ed && dec_op[7:6] == wide_load_pkg::GRP_ED_LS &&
                          dec_op[3:0] == wide_load_pkg::LOW_ED_LD;
  wire        st_ed     = is_ed && dec_op[7:6] == wide_load_pkg::GRP_ED_LS &&
                          dec_op[3:0] == wide_load_pkg::LOW_ED_ST;
  wire        ld_idx    = is_idx && dec_op == wide_load_pkg::OP_LD_DIR;
  wire        st_idx    = is_idx && dec_op == wide_load_pkg::OP_ST_DIR;
  wire        rfr       = is_ed && dec_op == wide_load_pkg::OP_RFR;
  wire        is_imm    = imm_pair || imm_idx;
  wire        is_ld     = ld_hl || ld_ed || ld_idx;
  wire        need_word = is_imm || is_ld || st_hl || st_ed || st_idx;
  // pair select field, third pair for the unprefixed direct forms
  assign sel = is_idx ? ((dec_pfx == wide_load_pkg::PFX_IDX_X) ? wide_load_pkg::SEL_IX
                                                                 : wide_load_pkg::SEL_IY)
             : (ld_hl || st_hl) ? wide_load_pkg::SEL_THIRD : {1'b0, dec_op[5:4]};
  wire [15:0] sel_word  = rp_r[sel];
  wire [15:0] word      = {mem_rdata_in, lo_r};
  wire [15:0] pc_nxt    = code_rd ? 16'(pc_r + 16'h0001) : pc_r;
  wire        nxt_code  = st_nxt == wide_load_pkg::ST_FETCH || st_nxt == wide_load_pkg::ST_FETCH2 ||
                          st_nxt == wide_load_pkg::ST_OPLO || st_nxt == wide_load_pkg::ST_OPHI;
  wire        nxt_wr    = st_nxt == wide_load_pkg::ST_WLO || st_nxt == wide_load_pkg::ST_WHI;
  wire [15:0] addr_nxt  = nxt_code ? pc_nxt : ea_nxt;
  wire        rd_nxt    = !nxt_wr && st_nxt != wide_load_pkg::ST_EXT;
  wire        instr_end = tick && st_nxt == wide_load_pkg::ST_FETCH;

  // machine cycle sequencing
  always_comb begin
    st_nxt  = st_r;
    pfx_nxt = pfx_r;
    len_nxt = wide_load_pkg::T_MEM;
    ea_nxt  = ea_r;
    wd_nxt  = wdata_r;
    reg_we  = 1'b0;
    case (st_r)
      wide_load_pkg::ST_FETCH: begin
        pfx_nxt = wide_load_pkg::PFX_NONE;
        if (is_prefix) begin
          st_nxt  = wide_load_pkg::ST_FETCH2;
          len_nxt = wide_load_pkg::T_FETCH;
          pfx_nxt = (mem_rdata_in == wide_load_pkg::PFX_X) ? wide_load_pkg::PFX_IDX_X :
                    (mem_rdata_in == wide_load_pkg::PFX_Y) ? wide_load_pkg::PFX_IDX_Y :
                                                             wide_load_pkg::PFX_EXT;
        end else if (need_word) begin
          st_nxt = wide_load_pkg::ST_OPLO;
        end else begin
          len_nxt = wide_load_pkg::T_FETCH;
        end
      end
      wide_load_pkg::ST_FETCH2: begin
        if (rfr) begin
          st_nxt  = wide_load_pkg::ST_EXT;
          len_nxt = wide_load_pkg::T_EXT;
        end else if (need_word) begin
          st_nxt = wide_load_pkg::ST_OPLO;
        end else begin
          st_nxt  = wide_load_pkg::ST_FETCH;
          len_nxt = wide_load_pkg::T_FETCH;
        end
      end
      wide_load_pkg::ST_OPLO: st_nxt = wide_load_pkg::ST_OPHI;
      wide_load_pkg::ST_OPHI: begin
        ea_nxt = word;
        if (is_imm) begin
          reg_we  = 1'b1;
          st_nxt  = wide_load_pkg::ST_FETCH;
          len_nxt = wide_load_pkg::T_FETCH;
        end else if (is_ld) begin
          st_nxt = wide_load_pkg::ST_DLO;
        end else begin
          st_nxt = wide_load_pkg::ST_WLO;
          wd_nxt = sel_word[7:0];
        end
      end
      wide_load_pkg::ST_DLO: begin
        st_nxt = wide_load_pkg::ST_DHI;
        ea_nxt = 16'(ea_r + 16'h0001);
      end
      wide_load_pkg::ST_DHI: begin
        reg_we  = 1'b1;
        st_nxt  = wide_load_pkg::ST_FETCH;
        len_nxt = wide_load_pkg::T_FETCH;
      end
      wide_load_pkg::ST_WLO: begin
        st_nxt = wide_load_pkg::ST_WHI;
        ea_nxt = 16'(ea_r + 16'h0001);
        wd_nxt = sel_word[15:8];
      end
      default: begin
        st_nxt  = wide_load_pkg::ST_FETCH;
        len_nxt = wide_load_pkg::T_FETCH;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r    <= wide_load_pkg::ST_FETCH;
      pfx_r   <= wide_load_pkg::PFX_NONE;
      pc_r    <= wide_load_pkg::PC_RST;
      ea_r    <= wide_load_pkg::WORD_RST;
      addr_r  <= wide_load_pkg::PC_RST;
      rd_r    <= 1'b1;
      wr_r    <= 1'b0;
      wdata_r <= wide_load_pkg::BYTE_RST;
    end else if (tick) begin
      st_r    <= st_nxt;
      pfx_r   <= pfx_nxt;
      pc_r    <= pc_nxt;
      ea_r    <= ea_nxt;
      addr_r  <= addr_nxt;
      rd_r    <= rd_nxt;
      wr_r    <= nxt_wr;
      wdata_r <= wd_nxt;
    end
  end

  // data capture and register file
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      op_r      <= wide_load_pkg::BYTE_RST;
      lo_r      <= wide_load_pkg::BYTE_RST;
      refresh_r <= wide_load_pkg::BYTE_RST;
      for (int i = 0; i < 6; i++) begin
        rp_r[i] <= wide_load_pkg::WORD_RST;
      end
    end else if (tick) begin
      if (st_r == wide_load_pkg::ST_FETCH || st_r == wide_load_pkg::ST_FETCH2) op_r <= mem_rdata_in;
      if (st_r == wide_load_pkg::ST_OPLO || st_r == wide_load_pkg::ST_DLO) lo_r <= mem_rdata_in;
      if (st_r == wide_load_pkg::ST_EXT) refresh_r <= acc_in;
      if (reg_we) rp_r[sel] <= word;
    end
  end

  // flags are owned by the core, untouched here
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flags_r <= wide_load_pkg::BYTE_RST;
      done_r  <= 1'b0;
    end else begin
      if (flags_wr_in) flags_r <= flags_in;
      done_r <= instr_end;
    end
  end

  assign mem_addr_out      = addr_r;
  assign mem_rd_out        = rd_r;
  assign mem_wr_out        = wr_r;
  assign mem_wdata_out     = wdata_r;
  assign first_pair_out    = rp_r[0];
  assign second_pair_out   = rp_r[1];
  assign third_pair_out    = rp_r[2];
  assign stack_pointer_out = rp_r[3];
  assign index_x_out       = rp_r[4];
  assign index_y_out       = rp_r[5];
  assign refresh_out       = refresh_r;
  assign flags_out         = flags_r;
  assign instr_done_out    = done_r;

  // clock states since the instruction began
  logic [4:0] tcnt_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) tcnt_r <= 5'h00;
    else tcnt_r <= instr_end ? 5'h00 : 5'(tcnt_r + 5'h01);
  end
  wire [4:0] tdone = 5'(tcnt_r + 5'h01);

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  chk_rfr_copy: assert property (
    tick && st_r == wide_load_pkg::ST_EXT |=> refresh_out == $past(acc_in))
    else $error("refresh not loaded from accumulator");
  chk_rfr_time: assert property (
    instr_end && rfr |-> tdone == wide_load_pkg::TOT_RFR)
    else $error("refresh load state count wrong");
  chk_flags_hold: assert property (
    !flags_wr_in |=> $stable(flags_out))
    else $error("flags changed by a load");
  chk_imm_pair: assert property (
    tick && st_r == wide_load_pkg::ST_OPHI && imm_pair && dec_op[5:4] == 2'h0
    |=> first_pair_out == $past(word) && instr_done_out)
    else $error("immediate pair load wrong");
  chk_imm_time: assert property (
    instr_end && imm_pair |-> tdone == wide_load_pkg::TOT_IMM)
    else $error("immediate pair state count wrong");
  chk_idx_time: assert property (
    instr_end && imm_idx |-> tdone == wide_load_pkg::TOT_IDX_IMM)
    else $error("immediate index state count wrong");
  chk_hl_time: assert property (
    instr_end && (ld_hl || st_hl) |-> tdone == wide_load_pkg::TOT_HL)
    else $error("third pair direct state count wrong");
  chk_ed_time: assert property (
    instr_end && (ld_ed || st_ed || ld_idx || st_idx) |-> tdone == wide_load_pkg::TOT_ED)
    else $error("prefixed direct state count wrong");
  chk_load_next: assert property (
    tick && st_r == wide_load_pkg::ST_DLO
    |=> mem_rd_out && mem_addr_out == 16'($past(mem_addr_out) + 16'h0001))
    else $error("high byte read not at next address");
  chk_idx_load: assert property (
    tick && st_r == wide_load_pkg::ST_DHI && ld_idx && pfx_r == wide_load_pkg::PFX_IDX_X
    |=> index_x_out == $past(word))
    else $error("index_x direct load wrong");
  chk_store_hi: assert property (
    tick && st_r == wide_load_pkg::ST_WLO |=> mem_wr_out &&
    mem_addr_out == 16'($past(mem_addr_out) + 16'h0001) && mem_wdata_out == $past(sel_word[15:8]))
    else $error("high byte store wrong");
  chk_code_fetch: assert property (
    code_rd |-> mem_rd_out && !mem_wr_out && mem_addr_out == pc_r)
    else $error("code byte not read at program counter");

  cov_rfr:     cover property (instr_end && rfr);
  cov_imm:     cover property (instr_end && imm_pair);
  cov_idx_ld:  cover property (instr_end && ld_idx);
  cov_ed_st:   cover property (instr_end && st_ed);
endmodule // wide_load_instr_exec

// ===== hdl/wide_load_pkg.sv
// constants, states and selectors of the sixteen-bit load executor
package wide_load_pkg;
  // prefix and opcode bytes
  localparam logic [7:0]  PFX_X       = 8'hDD;
  localparam logic [7:0]  PFX_Y       = 8'hFD;
  localparam logic [7:0]  PFX_E       = 8'hED;
  localparam logic [7:0]  OP_IDX_IMM  = 8'h21;
  localparam logic [7:0]  OP_LD_DIR   = 8'h2A;
  localparam logic [7:0]  OP_ST_DIR   = 8'h22;
  localparam logic [7:0]  OP_RFR      = 8'h4F;
  // opcode field layouts
  localparam logic [1:0]  GRP_IMM     = 2'h0;
  localparam logic [1:0]  GRP_ED_LS   = 2'h1;
  localparam logic [3:0]  LOW_IMM     = 4'h1;
  localparam logic [3:0]  LOW_ED_LD   = 4'hB;
  localparam logic [3:0]  LOW_ED_ST   = 4'h3;
  // clock states per machine cycle
  localparam logic [2:0]  T_FETCH     = 3'h4;
  localparam logic [2:0]  T_MEM       = 3'h3;
  localparam logic [2:0]  T_EXT       = 3'h1;
  // clock states per instruction
  localparam logic [4:0]  TOT_NOP     = 5'h04;
  localparam logic [4:0]  TOT_RFR     = 5'h09;
  localparam logic [4:0]  TOT_IMM     = 5'h0A;
  localparam logic [4:0]  TOT_IDX_IMM = 5'h0E;
  localparam logic [4:0]  TOT_HL      = 5'h10;
  localparam logic [4:0]  TOT_ED      = 5'h14;
  // register selector codes
  localparam logic [2:0]  SEL_FIRST   = 3'h0;
  localparam logic [2:0]  SEL_THIRD   = 3'h2;
  localparam logic [2:0]  SEL_IX      = 3'h4;
  localparam logic [2:0]  SEL_IY      = 3'h5;
  // reset values
  localparam logic [15:0] PC_RST      = 16'h0000;
  localparam logic [15:0] WORD_RST    = 16'h0000;
  localparam logic [7:0]  BYTE_RST    = 8'h00;

  typedef enum logic [3:0] {
    ST_FETCH, ST_FETCH2, ST_EXT, ST_OPLO, ST_OPHI, ST_DLO, ST_DHI, ST_WLO, ST_WHI
  } state_t;

  typedef enum logic [1:0] {PFX_NONE, PFX_IDX_X, PFX_IDX_Y, PFX_EXT} pfx_t;
endpackage

// ===== hdl/tstate_timer.sv
// clock-state counter marking the last state of each machine cycle
`timescale 1ns/1ps
module tstate_timer (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // length of the next machine cycle
  input  wire logic [2:0] len_in,
  // last clock state of the current machine cycle
  output wire logic       last_out
);
  logic [2:0] cnt_r;

  assign last_out = (cnt_r == 3'h1);

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt_r <= wide_load_pkg::T_FETCH;
    end else begin
      cnt_r <= last_out ? len_in : 3'(cnt_r - 3'h1);
    end
  end
endmodule // tstate_timer

// ===== bench/ext_mem_model.sv
// external memory answering the executor's read and write cycles
`timescale 1ns/1ps
module ext_mem_model (
  // clock
  input  wire logic        clk_in,
  // memory cycles
  input  wire logic [15:0] mem_addr_in,
  input  wire logic        mem_rd_in,
  input  wire logic        mem_wr_in,
  input  wire logic [7:0]  mem_wdata_in,
  output logic      [7:0]  mem_rdata_out
);
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
    mem_rdata_out = 8'h00;
  end
  // registered read, line toggles while no read is under way
  always @(posedge clk_in) begin
    if (mem_wr_in) begin
      mem[mem_addr_in] <= mem_wdata_in;
    end
    mem_rdata_out <= mem_rd_in ? mem[mem_addr_in] : ~mem_rdata_out;
  end
endmodule // ext_mem_model

// ===== bench/tb.sv
// self-checking bench of the sixteen-bit load executor
`timescale 1ns/1ps
module tb;
  typedef struct {int len; int r[7]; int acc; int st; int kind; int nxt;} exp_t;
  logic        clk_in, rst_n_in, mem_rd_out, mem_wr_out, flags_wr_in, instr_done_out;
  logic [15:0] mem_addr_out, first_pair_out, second_pair_out, third_pair_out;
  logic [15:0] stack_pointer_out, index_x_out, index_y_out;
  logic [7:0]  mem_wdata_out, mem_rdata_in, acc_in, flags_in, refresh_out, flags_out, flags_m;
  logic [15:0] seen [6];
  int miscompares = 0;
  int n_compared = 0;
  int pc = 0;
  int n_done = 0;
  int last_t = 0;
  int cyc = 0;
  int m [7];
  int md [int];
  int rend [$];
  exp_t exp_q [$];
  exp_t e;

  wide_load_instr_exec u_wide_load_instr_exec (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .mem_addr_out(mem_addr_out), .mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out),
    .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in), .acc_in(acc_in),
    .flags_wr_in(flags_wr_in), .flags_in(flags_in), .first_pair_out(first_pair_out),
    .second_pair_out(second_pair_out), .third_pair_out(third_pair_out),
    .stack_pointer_out(stack_pointer_out), .index_x_out(index_x_out),
    .index_y_out(index_y_out), .refresh_out(refresh_out), .flags_out(flags_out),
    .instr_done_out(instr_done_out));
  ext_mem_model u_ext_mem (.clk_in(clk_in), .mem_addr_in(mem_addr_out), .mem_rd_in(mem_rd_out),
    .mem_wr_in(mem_wr_out), .mem_wdata_in(mem_wdata_out), .mem_rdata_out(mem_rdata_in));

  task automatic chk(input logic [15:0] got, input logic [15:0] want);
    n_compared++;
    if (got !== want) begin
      miscompares++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, got, want);
    end
  endtask

  task automatic finish_test();
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  function automatic void emit(input int b);
    md[pc] = b & 255;
    u_ext_mem.mem[pc] = 8'(b);
    pc = pc + 1;
  endfunction

  function automatic int rd8(input int a);
    a = a & 32'hFFFF;
    if (!md.exists(a)) begin
      md[a] = $urandom % 256;
      u_ext_mem.mem[a] = 8'(md[a]);
    end
    return md[a];
  endfunction

  // one instruction of the given kind into memory and into the model
  function automatic void gen(input int k, input int a);
    int s;
    int w;
    s = $urandom % 4;
    w = $urandom % 65536;
    e.st = -1;
    e.kind = k;
    e.acc = $urandom % 256;
    if (k == 1 || k == 4) emit(s[0] ? wide_load_pkg::PFX_Y : wide_load_pkg::PFX_X);
    if (k == 3 || k == 6 || k == 7) emit(wide_load_pkg::PFX_E);
    case (k)
      0: emit(32'h01 + 16 * s);
      1: emit(wide_load_pkg::OP_IDX_IMM);
      2, 4: emit(wide_load_pkg::OP_LD_DIR);
      3: emit(32'h4B + 16 * s);
      5: emit(wide_load_pkg::OP_ST_DIR);
      6: emit(32'h43 + 16 * s);
      7: emit(wide_load_pkg::OP_RFR);
      default: emit(0);
    endcase
    if (k == 0 || k == 1) begin
      emit(w);
      emit(w >> 8);
    end
    if (k >= 2 && k <= 6) begin
      emit(a);
      emit(a >> 8);
    end
    w = (k == 0 || k == 1) ? w : rd8(a) + 256 * rd8(a + 1);
    case (k)
      0, 3: m[s] = w;
      1, 4: m[4 + s % 2] = w;
      2: m[2] = w;
      5, 6: e.st = a;
      7: m[6] = e.acc;
      default: ;
    endcase
    if (e.st >= 0) begin
      md[a] = m[k == 5 ? 2 : s] & 255;
      md[(a + 1) & 32'hFFFF] = m[k == 5 ? 2 : s] >> 8;
    end
    e.len = (k == 0) ? 10 : (k == 1) ? 14 : (k == 2 || k == 5) ? 16 : (k == 7) ? 9 : 20;
    e.len = (k == 8) ? 4 : e.len;
    e.r = m;
    e.nxt = pc;
    exp_q.push_back(e);
  endfunction

  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end

  // compare every finished instruction with the model
  always @(posedge clk_in) begin
    cyc = cyc + 1;
    if (rst_n_in === 1'b1 && instr_done_out === 1'b1 && n_done < exp_q.size()) begin
      e = exp_q[n_done];
      seen = '{first_pair_out, second_pair_out, third_pair_out, stack_pointer_out,
               index_x_out, index_y_out};
      if (n_done > 0) chk(16'(cyc - last_t), 16'(e.len));
      for (int i = 0; i < 6; i++) begin
        chk(seen[i], 16'(e.r[i]));
      end
      if (e.kind == 7) chk({8'h00, refresh_out}, 16'(e.r[6]));
      chk({8'h00, flags_out}, {8'h00, flags_m});
      chk({mem_rd_out, mem_addr_out}, {1'b1, 16'(e.nxt)});
      if (e.st >= 0) begin
        chk({u_ext_mem.mem[e.st], u_ext_mem.mem[16'(e.st + 1)]},
            {8'(md[e.st]), 8'(md[(e.st + 1) & 32'hFFFF])});
      end
      if (n_done + 1 < exp_q.size()) acc_in <= 8'(exp_q[n_done + 1].acc);
      last_t = cyc;
      n_done = n_done + 1;
    end
  end

  initial begin
    rst_n_in = 1'b0;
    acc_in = 8'h00;
    flags_in = 8'h00;
    flags_wr_in = 1'b0;
    flags_m = 8'h00;
    void'($urandom(32'h3767));
    repeat (4) @(posedge clk_in);
    m = '{default: 0};
    gen(8, 0);
    for (int r = 0; r < 6; r++) begin
      for (int k = 0; k < 9; k++) begin
        gen(k, (r == 0 && k == 2) ? 32'hFFFF : 32'h4000 + $urandom % 32'hBFFE);
      end
      rend.push_back(exp_q.size());
    end
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    flags_in <= 8'($urandom);
    flags_wr_in <= 1'b1;
    @(posedge clk_in);
    flags_wr_in <= 1'b0;
    flags_m = flags_in;
    for (int r = 0; r < 6; r++) begin
      for (int t = 0; t < 3000 && n_done < rend[r]; t++) @(posedge clk_in);
      chk(16'(n_done >= rend[r]), 16'h0001);
      $display("round %0d ended, %0d instructions, %0d mismatches", r, n_done, miscompares);
    end
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    finish_test();
  end
endmodule // tb
